// [verilog/gbx_core.sv]
// Operation
// - side A data-valid asserted makes A the source, clears B source.
// - side B data-valid asserted makes B the source, clears A source.
// - poll start or any attention change clears both source states.
// - B data drives A while B is source or A runs a poll.
// - A data drives B while A is source or B runs a poll.
// - poll on A is re-run on B, response driven onto A.
// - poll on B is re-run on A, response driven onto B.
// - drivers three-state, open-collector during a parallel poll.
// - each side looks like a full-function talker, listener, controller device.
// - eight data lines carry 7-bit commands and data, eighth optional.
// - byte transfer uses interlocked data-valid, ready, accepted handshake.
// - reset clears system, active controller and source states both sides.
// - interface clear or remote enable on a side marks it system controller.
// - attention on a side marks it active controller.
// - sense or drive of each line follows the three side states.
module gbx_core #(
    parameter int DATA_W     = gbx_pkg::DATA_W,       // data lines per side
    parameter int CTL_W      = gbx_pkg::CTL_W,        // management and handshake lines
    parameter int SYNC_DEPTH = gbx_pkg::SYNC_STAGES   // flops ahead of the state logic
) (
    input  wire logic       CLOCK_I,        // 20 MHz core clock
    input  wire logic       RST_N_I,        // async reset, active low
    input  wire logic [7:0] A_DATA_I,       // side A data lines, sensed
    output logic      [7:0] A_DATA_O,       // side A data drive level
    output logic      [7:0] A_DATA_OE_O,    // side A data drive enable
    input  wire logic [7:0] A_CTL_I,        // side A control lines, sensed
    output logic      [7:0] A_CTL_O,        // side A control drive level
    output logic      [7:0] A_CTL_OE_O,     // side A control drive enable
    input  wire logic [7:0] B_DATA_I,       // side B data lines, sensed
    output logic      [7:0] B_DATA_O,       // side B data drive level
    output logic      [7:0] B_DATA_OE_O,    // side B data drive enable
    input  wire logic [7:0] B_CTL_I,        // side B control lines, sensed
    output logic      [7:0] B_CTL_O,        // side B control drive level
    output logic      [7:0] B_CTL_OE_O,     // side B control drive enable
    output logic            A_OPEN_COLL_O,  // side A drivers open-collector
    output logic            B_OPEN_COLL_O,  // side B drivers open-collector
    output logic            A_SYS_CTL_O,    // side A holds system controller
    output logic            B_SYS_CTL_O,    // side B holds system controller
    output logic            A_ACT_CTL_O,    // side A holds active controller
    output logic            B_ACT_CTL_O,    // side B holds active controller
    output logic            A_SRC_HS_O,     // side A holds source handshake
    output logic            B_SRC_HS_O      // side B holds source handshake
);
    typedef struct packed {
        logic       sys_a, sys_b, act_a, act_b, src_a, src_b;
        logic       atn_prev, ppoll_prev;
        logic [7:0] a_dat, a_doe, a_ctl, a_coe;
        logic [7:0] b_dat, b_doe, b_ctl, b_coe;
        logic       oc_a, oc_b;
        // control enables delayed by the sync depth, for the echo mask
        logic [7:0] a_coe_d1, a_coe_d2, b_coe_d1, b_coe_d2;
    } gbx_core_t;

    gbx_core_t st;
    gbx_core_t next_st;

    // line positions are fixed by the bus, so other widths cannot be served
    if (DATA_W != 8) begin : g_bad_data_w
        $error("gbx_core: DATA_W must be 8");
    end
    if (CTL_W != 8) begin : g_bad_ctl_w
        $error("gbx_core: CTL_W must be 8");
    end
    // the echo mask is delayed to match exactly two sync flops
    if (SYNC_DEPTH != 2) begin : g_bad_sync
        $error("gbx_core: SYNC_DEPTH must be 2");
    end

    logic [7:0] a_dsy, a_csy, b_dsy, b_csy;
    logic [7:0] a_dl, a_cl, b_dl, b_cl;
    logic [3:0][7:0] raw_in;
    logic [3:0][7:0] syn_out;

    assign raw_in = {B_CTL_I, B_DATA_I, A_CTL_I, A_DATA_I};

    // data and control lines both idle high, so one reset value serves all lanes
    for (genvar g = 0; g < 4; g++) begin : g_sync
        gbx_sync #(
            .WIDTH   (8),
            .RST_VAL (gbx_pkg::DATA_IDLE)
        ) u_sync (
            .CLOCK_I (CLOCK_I),
            .RST_N_I (RST_N_I),
            .D_I     (raw_in[g]),
            .Q_O     (syn_out[g])
        );
    end

    assign a_dsy = syn_out[0];
    assign a_csy = syn_out[1];
    assign b_dsy = syn_out[2];
    assign b_csy = syn_out[3];

    // our own drive is masked so the sense path only sees the far devices
    function automatic logic [7:0] far_true(input logic [7:0] lvl, input logic [7:0] oe);
        far_true = ~lvl & ~oe;
    endfunction : far_true

    // a poll is attention and identify both true from the far devices
    function automatic logic poll_seen(input logic [7:0] cl);
        poll_seen = cl[gbx_pkg::ATN_BIT] & cl[gbx_pkg::EOI_BIT];
    endfunction : poll_seen

    assign a_dl = ~a_dsy;
    assign b_dl = ~b_dsy;
    // mask with the enable that drove the sampled level, two flops back; the live
    // enable would let our own release echo back as a far assertion
    assign a_cl = far_true(a_csy, st.a_coe_d2);
    assign b_cl = far_true(b_csy, st.b_coe_d2);

    logic atn_any, pp_a, pp_b, pp_any;
    logic [7:0] a_want, b_want;

    always_comb begin
        next_st = st;
        atn_any = a_cl[gbx_pkg::ATN_BIT] | b_cl[gbx_pkg::ATN_BIT];
        // poll = attention and identify together, sensed separately on each side
        pp_a = poll_seen(a_cl);
        pp_b = poll_seen(b_cl);
        pp_any = pp_a | pp_b;
        next_st.atn_prev   = atn_any;
        next_st.ppoll_prev = pp_any;
        if (a_cl[gbx_pkg::IFC_BIT] | a_cl[gbx_pkg::REN_BIT]) begin
            next_st.sys_a = 1'b1;
            next_st.sys_b = 1'b0;
        end else if (b_cl[gbx_pkg::IFC_BIT] | b_cl[gbx_pkg::REN_BIT]) begin
            next_st.sys_a = 1'b0;
            next_st.sys_b = 1'b1;
        end
        if (a_cl[gbx_pkg::ATN_BIT]) begin
            next_st.act_a = 1'b1;
            next_st.act_b = 1'b0;
        end else if (b_cl[gbx_pkg::ATN_BIT]) begin
            next_st.act_a = 1'b0;
            next_st.act_b = 1'b1;
        end
        // clearing events take priority over a new data-valid
        if ((pp_any & ~st.ppoll_prev) | (atn_any ^ st.atn_prev)) begin
            next_st.src_a = 1'b0;
            next_st.src_b = 1'b0;
        end else if (a_cl[gbx_pkg::DAV_BIT]) begin
            next_st.src_a = 1'b1;
            next_st.src_b = 1'b0;
        end else if (b_cl[gbx_pkg::DAV_BIT]) begin
            next_st.src_a = 1'b0;
            next_st.src_b = 1'b1;
        end
        // data direction, poll response relayed back
        next_st.a_dat = ~b_dl;
        next_st.b_dat = ~a_dl;
        next_st.a_doe = {8{st.src_b | pp_a}};
        next_st.b_doe = {8{st.src_a | pp_b}};
        // during poll only low is driven, high is released
        next_st.oc_a = pp_a | pp_b;
        next_st.oc_b = pp_a | pp_b;
        if (pp_any) begin
            next_st.a_doe = next_st.a_doe & b_dl;
            next_st.b_doe = next_st.b_doe & a_dl;
        end
        // control relay gated by side states
        a_want = 8'h00;
        b_want = 8'h00;
        a_want[gbx_pkg::IFC_BIT] = st.sys_b & b_cl[gbx_pkg::IFC_BIT];
        a_want[gbx_pkg::REN_BIT] = st.sys_b & b_cl[gbx_pkg::REN_BIT];
        b_want[gbx_pkg::IFC_BIT] = st.sys_a & a_cl[gbx_pkg::IFC_BIT];
        b_want[gbx_pkg::REN_BIT] = st.sys_a & a_cl[gbx_pkg::REN_BIT];
        a_want[gbx_pkg::ATN_BIT] = st.act_b & b_cl[gbx_pkg::ATN_BIT];
        b_want[gbx_pkg::ATN_BIT] = st.act_a & a_cl[gbx_pkg::ATN_BIT];
        a_want[gbx_pkg::EOI_BIT] = (st.src_b | pp_b) & b_cl[gbx_pkg::EOI_BIT];
        b_want[gbx_pkg::EOI_BIT] = (st.src_a | pp_a) & a_cl[gbx_pkg::EOI_BIT];
        // service request flows toward the active controller
        a_want[gbx_pkg::SRQ_BIT] = st.act_a & b_cl[gbx_pkg::SRQ_BIT];
        b_want[gbx_pkg::SRQ_BIT] = st.act_b & a_cl[gbx_pkg::SRQ_BIT];
        // acceptor side gets data-valid, source side gets the acceptors' answer
        a_want[gbx_pkg::DAV_BIT]  = st.src_b & b_cl[gbx_pkg::DAV_BIT];
        b_want[gbx_pkg::DAV_BIT]  = st.src_a & a_cl[gbx_pkg::DAV_BIT];
        a_want[gbx_pkg::NRFD_BIT] = st.src_a & b_cl[gbx_pkg::NRFD_BIT];
        a_want[gbx_pkg::NDAC_BIT] = st.src_a & b_cl[gbx_pkg::NDAC_BIT];
        b_want[gbx_pkg::NRFD_BIT] = st.src_b & a_cl[gbx_pkg::NRFD_BIT];
        b_want[gbx_pkg::NDAC_BIT] = st.src_b & a_cl[gbx_pkg::NDAC_BIT];
        // lines are open-collector in nature: drive low when true, else release
        next_st.a_coe = a_want;
        next_st.b_coe = b_want;
        next_st.a_ctl = ~a_want;
        next_st.b_ctl = ~b_want;
        // enable history follows the sense path latency
        next_st.a_coe_d1 = st.a_coe;
        next_st.a_coe_d2 = st.a_coe_d1;
        next_st.b_coe_d1 = st.b_coe;
        next_st.b_coe_d2 = st.b_coe_d1;
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st       <= '0;
            st.a_dat <= gbx_pkg::DATA_IDLE;
            st.b_dat <= gbx_pkg::DATA_IDLE;
            st.a_ctl <= gbx_pkg::CTL_IDLE;
            st.b_ctl <= gbx_pkg::CTL_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // all eight data lines pass untouched, any code set
    assign A_DATA_O      = st.a_dat;
    assign A_DATA_OE_O   = st.a_doe;
    assign B_DATA_O      = st.b_dat;
    assign B_DATA_OE_O   = st.b_doe;
    assign A_CTL_O       = st.a_ctl;
    assign A_CTL_OE_O    = st.a_coe;
    assign B_CTL_O       = st.b_ctl;
    assign B_CTL_OE_O    = st.b_coe;
    assign A_OPEN_COLL_O = st.oc_a;
    assign B_OPEN_COLL_O = st.oc_b;
    assign A_SYS_CTL_O   = st.sys_a;
    assign B_SYS_CTL_O   = st.sys_b;
    assign A_ACT_CTL_O   = st.act_a;
    assign B_ACT_CTL_O   = st.act_b;
    assign A_SRC_HS_O    = st.src_a;
    assign B_SRC_HS_O    = st.src_b;
endmodule : gbx_core

// [verilog/gbx_pkg.sv]
package gbx_pkg;
    localparam int          SYNC_STAGES = 2;
    localparam int          DATA_W      = 8;
    localparam logic        ASSERTED    = 1'b0;   // bus lines are active low
    localparam logic        RELEASED    = 1'b1;
    // control line indices within the management and handshake group
    localparam int          ATN_BIT     = 0;
    localparam int          IFC_BIT     = 1;
    localparam int          REN_BIT     = 2;
    localparam int          SRQ_BIT     = 3;
    localparam int          EOI_BIT     = 4;
    localparam int          DAV_BIT     = 5;
    localparam int          NRFD_BIT    = 6;
    localparam int          NDAC_BIT    = 7;
    localparam int          CTL_W       = 8;
    localparam logic [7:0]  CTL_IDLE    = 8'hff;
    localparam logic [7:0]  DATA_IDLE   = 8'hff;
endpackage : gbx_pkg

// [verilog/gbx_sync.sv]
// two-flop synchroniser; first stage feeds only the second
module gbx_sync #(
    parameter int         WIDTH    = 8,
    parameter logic [7:0] RST_VAL  = 8'hff
) (
    input  wire logic             CLOCK_I,   // core clock
    input  wire logic             RST_N_I,   // async reset, active low
    input  wire logic [WIDTH-1:0] D_I,       // asynchronous bus levels
    output logic      [WIDTH-1:0] Q_O        // synchronised levels
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } gbx_sync_t;

    gbx_sync_t st;
    gbx_sync_t next_st;

    // reset value is one byte wide, so wider lanes cannot be served
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("gbx_sync: WIDTH out of range");
    end

    always_comb begin
        next_st    = st;
        next_st.s1 = D_I;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st <= {RST_VAL[WIDTH-1:0], RST_VAL[WIDTH-1:0]};
        end else begin
            st <= next_st;
        end
    end

    assign Q_O = st.s2;
endmodule : gbx_sync

// [tb/gbx_sva.sv]
module gbx_sva (
    input wire logic       CLOCK_I,        // core clock
    input wire logic       RST_N_I,        // async reset
    input wire logic [7:0] A_DATA_I,       // side A data sensed
    input wire logic [7:0] A_CTL_I,        // side A control sensed
    input wire logic [7:0] A_CTL_OE_O,     // side A control enables
    input wire logic [7:0] A_DATA_OE_O,    // side A data enables
    input wire logic [7:0] B_DATA_O,       // side B data level
    input wire logic [7:0] B_DATA_OE_O,    // side B data enables
    input wire logic       A_OPEN_COLL_O,  // side A poll mode
    input wire logic       A_SYS_CTL_O,    // side A system ctl
    input wire logic       A_ACT_CTL_O,    // side A active ctl
    input wire logic       A_SRC_HS_O,     // side A source
    input wire logic       B_SRC_HS_O      // side B source
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    a_src_excl: assert property (!(A_SRC_HS_O && B_SRC_HS_O))
        else $error("both sides source");
    a_src_cause: assert property ($rose(A_SRC_HS_O) |-> !$past(A_CTL_I[5], 3))
        else $error("a source without valid");
    a_sys_cause: assert property ($rose(A_SYS_CTL_O) |-> $past(A_CTL_I[2:1], 3) != 2'h3)
        else $error("a system ctl without cause");
    a_act_cause: assert property ($rose(A_ACT_CTL_O) |-> !$past(A_CTL_I[0], 3))
        else $error("a active ctl without attention");
    a_poll_clear: assert property ($rose(A_OPEN_COLL_O) |-> !A_SRC_HS_O && !B_SRC_HS_O)
        else $error("source kept at poll start");
    // only a poll raised by a device counts; our own relayed lines are not sensed
    a_poll_mode: assert property ($past(RST_N_I, 4)
        && $past({A_CTL_I[4], A_CTL_I[0], A_CTL_OE_O[4], A_CTL_OE_O[0]}, 3) == 4'h0
        |-> A_OPEN_COLL_O) else $error("a poll without open collector");
    a_dir_b2a: assert property (A_DATA_OE_O != 8'h00 |-> B_SRC_HS_O || A_OPEN_COLL_O
        || $past(B_SRC_HS_O) || $past(A_OPEN_COLL_O)) else $error("a driven without cause");
    a_pass_a2b: assert property (B_DATA_OE_O == 8'hff |-> B_DATA_O == $past(A_DATA_I, 3))
        else $error("a data not passed to b");
    c_src_a: cover property ($rose(A_SRC_HS_O));
    c_src_b: cover property ($rose(B_SRC_HS_O));
    c_poll_a: cover property ($rose(A_OPEN_COLL_O));
endmodule : gbx_sva

bind gbx_core gbx_sva gbx_sva_inst (.*);

// [tb/gbx_bus_model.sv]
module gbx_bus_model #(
    parameter int DELAY = 0  // listener cycles before it takes a byte
) (
    input  wire logic       clk_i,       // core clock
    input  wire logic [7:0] dev_ctl_i,   // device control pulls, low = true
    input  wire logic [7:0] dev_data_i,  // device data pulls
    input  wire logic [7:0] ppr_i,       // poll answer bits, high = respond
    input  wire logic [7:0] ctl_i,       // expander control level
    input  wire logic [7:0] ctl_oe_i,    // expander control enable
    input  wire logic [7:0] data_i,      // expander data level
    input  wire logic [7:0] data_oe_i,   // expander data enable
    output logic      [7:0] ctl_o,       // control wire, pulled up
    output logic      [7:0] data_o       // data wire, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] held = 4'h0;  // cycles data valid has been seen
    always @(posedge clk_i)
        held <= ctl_o[5] ? 4'h0 : held + {3'h0, held != 4'hf};
    // listener stays not-accepted until it held the byte, slow when DELAY is large
    assign ctl_o = dev_ctl_i & (ctl_i | ~ctl_oe_i)
        & {held > DELAY[3:0], held == 4'h0, 6'h3f};
    assign data_o = dev_data_i & (data_i | ~data_oe_i)
        & ~((!ctl_o[0] && !ctl_o[4]) ? ppr_i : 8'h00);
endmodule : gbx_bus_model

// [tb/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] a_dev = 8'hff, b_dev = 8'hff, a_dd = 8'hff, b_dd = 8'hff;
    logic [7:0] a_ppr = 8'h00, b_ppr = 8'h00, v;
    logic [7:0] a_ctl, b_ctl, a_dat, b_dat, a_do, a_doe, a_co, a_coe;
    logic [7:0] b_do, b_doe, b_co, b_coe;
    logic       a_oc, b_oc, a_sys, b_sys, a_act, b_act, a_src, b_src;
    int         n_errors = 0, comparisons = 0, seed = 27198, cycles = 0;
    logic [7:0] sent[$];  // bytes owed to side B, oldest first
    gbx_core gbx_core_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
        .A_DATA_I(a_dat), .A_DATA_O(a_do), .A_DATA_OE_O(a_doe),
        .A_CTL_I(a_ctl), .A_CTL_O(a_co), .A_CTL_OE_O(a_coe),
        .B_DATA_I(b_dat), .B_DATA_O(b_do), .B_DATA_OE_O(b_doe),
        .B_CTL_I(b_ctl), .B_CTL_O(b_co), .B_CTL_OE_O(b_coe),
        .A_OPEN_COLL_O(a_oc), .B_OPEN_COLL_O(b_oc), .A_SYS_CTL_O(a_sys),
        .B_SYS_CTL_O(b_sys), .A_ACT_CTL_O(a_act), .B_ACT_CTL_O(b_act),
        .A_SRC_HS_O(a_src), .B_SRC_HS_O(b_src));
    gbx_bus_model #(.DELAY(0)) model_a (.clk_i(clk), .dev_ctl_i(a_dev), .dev_data_i(a_dd),
        .ppr_i(a_ppr), .ctl_i(a_co), .ctl_oe_i(a_coe), .data_i(a_do), .data_oe_i(a_doe),
        .ctl_o(a_ctl), .data_o(a_dat));
    gbx_bus_model #(.DELAY(9)) model_b (.clk_i(clk), .dev_ctl_i(b_dev), .dev_data_i(b_dd),
        .ppr_i(b_ppr), .ctl_i(b_co), .ctl_oe_i(b_coe), .data_i(b_do), .data_oe_i(b_doe),
        .ctl_o(b_ctl), .data_o(b_dat));
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("%0d compares, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic look(input int n);
        wt(n);
        @(negedge clk);
    endtask : look
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin  // whole run needs about 140 cycles
            n_errors++;
            conclude();
        end
    end
    initial begin
        wt(3);
        rst_n <= 1'b1;
        look(3);
        chk({a_sys, b_sys, a_act, b_act, a_src, b_src, a_oc, b_oc}, 8'h00);
        chk(a_doe | b_doe | a_coe | b_coe, 8'h00);
        wt(1);
        a_dev <= 8'hfc;  // attention and clear from side A
        look(8);
        chk({4'h0, a_sys, b_sys, a_act, b_act}, 8'h0a);
        wt(1);
        a_dev <= 8'hff;
        b_dev <= 8'hfb;  // remote enable from side B
        look(8);
        chk({4'h0, a_sys, b_sys, a_act, b_act}, 8'h06);
        $display("controller test done");
        wt(1);
        b_dev <= 8'hf7;  // service request from side B, controller on A
        look(4);
        chk({6'h0, a_coe[3], a_co[3]}, 8'h02);
        chk({7'h0, b_coe[3]}, 8'h00);
        $display("service request test done");
        wt(1);
        b_dev <= 8'hff;
        for (int i = 0; i < 4; i++) begin
            wt(1);
            v = 8'($random(seed));
            sent.push_back(v);
            a_dd <= v;
            a_dev <= 8'hdf;  // talker on A holds data valid
            look(6);
            chk(b_do, sent.pop_front());
            chk({6'h0, a_src, b_src}, 8'h02);
            chk(b_doe, 8'hff);
            chk({7'h0, b_coe[5]}, 8'h01);
        end
        wt(1);
        a_dev <= 8'hfe;  // valid off and attention on together
        look(8);
        chk({6'h0, a_src, b_src}, 8'h00);
        chk(b_doe, 8'h00);
        $display("a to b test done");
        wt(1);
        a_dev <= 8'hff;
        wt(8);
        v = 8'($random(seed));
        b_dd <= v;
        b_dev <= 8'hdf;
        look(8);
        chk({6'h0, a_src, b_src}, 8'h01);
        chk(a_doe, 8'hff);
        chk(a_do, v);
        wt(1);
        b_dev <= 8'hff;
        a_dev <= 8'hdf;  // A takes over while the B relay still drains
        look(10);
        chk({6'h0, a_src, b_src}, 8'h02);
        $display("b to a test done");
        for (int s = 0; s < 2; s++) begin
            wt(1);
            v = 8'($random(seed));
            a_dev <= (s == 0) ? 8'hee : 8'hff;  // attention with identify polls
            b_dev <= (s == 0) ? 8'hff : 8'hee;
            a_ppr <= (s == 0) ? 8'h00 : v;
            b_ppr <= (s == 0) ? v : 8'h00;
            a_dd <= 8'hff;  // earlier payloads must not mask the poll answer
            b_dd <= 8'hff;
            look(20);
            chk({6'h0, a_oc, b_oc}, 8'h03);
            chk({6'h0, a_src, b_src}, 8'h00);
            chk((s == 0) ? a_doe : b_doe, v);
            chk((s == 0) ? a_dat : b_dat, ~v);
            $display("poll test %0d done", s);
        end
        conclude();
    end
endmodule : tb_top
